// [common/seq_consts.vh]
`ifndef SEQ_CONSTS_VH
`define SEQ_CONSTS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_CONTROL    8'h00
`define OFS_STACK_PTR  8'h04
`define OFS_STATUS     8'h08
`define OFS_PROG_CNT   8'h0c

// ****************************************
// Field positions
// ****************************************
`define CTRL_MASK_BIT  0
`define STAT_MASK_BIT  8
`define STAT_NMI_BIT   9
`define STAT_IRQ_BIT   10
`define STAT_BA_BIT    11
`define FLAGS_MASK_BIT 4

// ****************************************
// Reset values and vectors
// ****************************************
`define SP_RESET       16'h0000
`define RESET_ADDR     16'hfffe
`define VEC_RESET      16'hfffe
`define VEC_NMI        16'hfffc
`define VEC_IRQ        16'hfff8
`define FLAGS_UNUSED   2'h3

// ****************************************
// Sequence counts
// ****************************************
`define STACK_BYTES    3'h7
`define RESET_SETTLE_CYCLES 8

`endif

// [rtl/bus_int_sequencer.v]
// How it works
// - Address pins float while bus float request is high.
// - Data pins driven only while data drive enable is high.
// - Data drivers stay off during every read cycle.
// - Halt or wait raises bus released, drivers off, outputs inactive.
// - Wait ends on pending NMI, or IRQ with mask clear.
// - Bus float request forces bus released low.
// - Read-not-write high for reads and idle, low for writes.
// - Read-not-write floats under bus float request or halt.
// - Restart loads PC from FFFE then FFFF, then runs.
// - Restart sets the interrupt mask bit.
// - In reset: address valid low, released low, read, FFFE.
// - Restart begins the cycle after reset is seen high.
// - IRQ level checked at instruction end; replaces next fetch.
// - Interrupt pushes PC, index, accumulators, flags; sets mask.
// - NMI vector at FFFC/FFFD, IRQ vector at FFF8/FFF9.
// - Interrupts serviced only with halt released, except in wait; NMI latched meanwhile.
// - NMI taken on falling edge, ignores the mask.
// - Return pulls everything back and restores the mask.
// - Wait op stacks first, releases bus, services without restack.
// - Bus float request forces address valid low.
// - Address valid output is never three-stated.
// - Halt request low halts after the current instruction.
`timescale 1ns/1ps
`include "seq_consts.vh"

module bus_int_sequencer (
  input  wire        CLOCK_I,
  input  wire        RST_N_I,
  input  wire        CE_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output wire        PREADY_O,
  output wire        PSLVERR_O,
  input  wire        BUS_FLOAT_REQUEST_I,
  input  wire        DATA_DRIVE_ENABLE_I,
  input  wire        HALT_N_I,
  input  wire        IRQ_N_I,
  input  wire        NMI_N_I,
  output wire [15:0] ADDR_O,
  output wire        ADDR_OE_O,
  input  wire [7:0]  DATA_I,
  output wire [7:0]  DATA_O,
  output wire        DATA_OE_O,
  output wire        RNW_O,
  output wire        RNW_OE_O,
  output wire        ADDRESS_VALID_O,
  output wire        BUS_RELEASED_O,
  input  wire        INSTR_DONE_I,
  input  wire        WAIT_FOR_INTERRUPT_OP_I,
  input  wire        RETURN_FROM_INTERRUPT_OP_I,
  input  wire [15:0] CORE_ADDR_I,
  input  wire [7:0]  CORE_WDATA_I,
  input  wire        CORE_RNW_I,
  input  wire        CORE_VALID_I,
  input  wire [15:0] CORE_PC_I,
  input  wire [15:0] INDEX_REG_I,
  input  wire [15:0] ACCUMULATORS_I,
  input  wire [7:0]  CONDITION_FLAGS_I,
  output wire        RUN_O,
  output reg  [15:0] PC_O,
  output reg         LOAD_PC_O,
  output reg  [15:0] INDEX_REG_O,
  output reg  [15:0] ACCUMULATORS_O,
  output reg  [7:0]  CONDITION_FLAGS_O,
  output reg         RESTORE_O
);

  // ****************************************
  // States
  // ****************************************
  localparam [7:0] S_RESET = 8'h01;
  localparam [7:0] S_VECHI = 8'h02;
  localparam [7:0] S_VECLO = 8'h04;
  localparam [7:0] S_RUN   = 8'h08;
  localparam [7:0] S_PUSH  = 8'h10;
  localparam [7:0] S_WAIT  = 8'h20;
  localparam [7:0] S_PULL  = 8'h40;
  localparam [7:0] S_HALT  = 8'h80;

  reg  [7:0]  state_reg;
  reg  [7:0]  state_next;
  reg  [2:0]  cnt_reg;
  reg  [2:0]  cnt_next;
  reg  [15:0] sp_reg;
  reg  [15:0] sp_next;
  reg  [15:0] pc_next;
  reg  [15:0] vec_reg;
  reg  [15:0] vec_next;
  reg         mask_reg;
  reg         mask_next;
  reg         nmi_pend_reg;
  reg         nmi_pend_next;
  reg         nmi_d_reg;
  reg         wai_reg;
  reg         wai_next;
  reg         load_next;
  reg         restore_next;
  reg  [15:0] ix_next;
  reg  [15:0] acc_next;
  reg  [7:0]  flags_next;
  reg  [15:0] addr_reg;
  reg  [15:0] addr_next;
  reg  [7:0]  wd_reg;
  reg  [7:0]  wd_next;
  reg         rnw_reg;
  reg         rnw_next;
  reg         vma_reg;
  reg         vma_next;
  reg         ba_reg;
  reg         ba_next;

  wire nmi_fall = nmi_d_reg & ~NMI_N_I;
  wire irq_ok   = ~IRQ_N_I & ~mask_reg;
  wire take_int = nmi_pend_reg | irq_ok;
  wire apb_wr   = PSEL_I & PENABLE_I & PWRITE_I & CE_I;
  wire freeze   = BUS_FLOAT_REQUEST_I;

  // ****************************************
  // Helpers
  // ****************************************
  function [7:0] push_byte;
    input [2:0]  idx;
    input [15:0] pc;
    input [15:0] ix;
    input [15:0] acc;
    input [7:0]  fl;
    input        msk;
    begin
      case (idx)
        3'h0: push_byte = pc[7:0];
        3'h1: push_byte = pc[15:8];
        3'h2: push_byte = ix[7:0];
        3'h3: push_byte = ix[15:8];
        3'h4: push_byte = acc[7:0];
        3'h5: push_byte = acc[15:8];
        default: push_byte = {`FLAGS_UNUSED, fl[5], msk, fl[3:0]};
      endcase
    end
  endfunction

  function known_addr;
    input [7:0] a;
    begin
      known_addr = (a == `OFS_CONTROL) || (a == `OFS_STACK_PTR) ||
                   (a == `OFS_STATUS)  || (a == `OFS_PROG_CNT);
    end
  endfunction

  // ****************************************
  // Sequencer next state
  // ****************************************
  always @* begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    sp_next       = sp_reg;
    pc_next       = PC_O;
    vec_next      = vec_reg;
    mask_next     = mask_reg;
    nmi_pend_next = nmi_pend_reg;
    wai_next      = wai_reg;
    load_next     = 1'b0;
    restore_next  = 1'b0;
    ix_next       = INDEX_REG_O;
    acc_next      = ACCUMULATORS_O;
    flags_next    = CONDITION_FLAGS_O;
    if (apb_wr && PADDR_I == `OFS_CONTROL) begin
      mask_next = PWDATA_I[`CTRL_MASK_BIT];
    end
    if (apb_wr && PADDR_I == `OFS_STACK_PTR) begin
      sp_next = PWDATA_I[15:0];
    end
    if (!freeze) begin
      case (state_reg)
        S_RESET: begin
          state_next = S_VECHI;
          vec_next   = `VEC_RESET;
          mask_next  = 1'b1;
        end
        S_VECHI: begin
          pc_next[15:8] = DATA_I;
          state_next    = S_VECLO;
        end
        S_VECLO: begin
          pc_next[7:0] = DATA_I;
          load_next    = 1'b1;
          state_next   = S_RUN;
        end
        S_RUN: begin
          if (RETURN_FROM_INTERRUPT_OP_I) begin
            state_next = S_PULL;
            cnt_next   = 3'h0;
          end else if (WAIT_FOR_INTERRUPT_OP_I) begin
            state_next = S_PUSH;
            cnt_next   = 3'h0;
            wai_next   = 1'b1;
          end else if (INSTR_DONE_I) begin
            if (!HALT_N_I) begin
              state_next = S_HALT;
            end else if (take_int) begin
              state_next = S_PUSH;
              cnt_next   = 3'h0;
              wai_next   = 1'b0;
            end
          end
        end
        S_PUSH: begin
          sp_next  = sp_reg - 16'h0001;
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == `STACK_BYTES - 3'h1) begin
            if (wai_reg) begin
              state_next = S_WAIT;
            end else begin
              state_next    = S_VECHI;
              mask_next     = 1'b1;
              vec_next      = nmi_pend_reg ? `VEC_NMI : `VEC_IRQ;
              nmi_pend_next = 1'b0;
            end
          end
        end
        S_WAIT: begin
          if (take_int) begin
            state_next    = S_VECHI;
            mask_next     = 1'b1;
            vec_next      = nmi_pend_reg ? `VEC_NMI : `VEC_IRQ;
            nmi_pend_next = 1'b0;
            wai_next      = 1'b0;
          end
        end
        S_PULL: begin
          sp_next  = sp_reg + 16'h0001;
          cnt_next = cnt_reg + 3'h1;
          case (cnt_reg)
            3'h0: flags_next      = DATA_I;
            3'h1: acc_next[15:8]  = DATA_I;
            3'h2: acc_next[7:0]   = DATA_I;
            3'h3: ix_next[15:8]   = DATA_I;
            3'h4: ix_next[7:0]    = DATA_I;
            3'h5: pc_next[15:8]   = DATA_I;
            default: pc_next[7:0] = DATA_I;
          endcase
          if (cnt_reg == `STACK_BYTES - 3'h1) begin
            mask_next    = CONDITION_FLAGS_O[`FLAGS_MASK_BIT];
            load_next    = 1'b1;
            restore_next = 1'b1;
            state_next   = S_RUN;
          end
        end
        S_HALT: begin
          if (HALT_N_I) begin
            if (take_int) begin
              state_next = S_PUSH;
              cnt_next   = 3'h0;
              wai_next   = 1'b0;
            end else begin
              state_next = S_RUN;
            end
          end
        end
        default: state_next = S_RESET;
      endcase
    end
    if (nmi_fall) begin
      nmi_pend_next = 1'b1;
    end
  end

  // ****************************************
  // Bus cycle for the next state
  // ****************************************
  always @* begin
    addr_next = CORE_ADDR_I;
    wd_next   = CORE_WDATA_I;
    rnw_next  = 1'b1;
    vma_next  = 1'b0;
    ba_next   = 1'b0;
    case (state_next)
      S_RESET: addr_next = `RESET_ADDR;
      S_VECHI: begin
        addr_next = vec_next;
        vma_next  = 1'b1;
      end
      S_VECLO: begin
        addr_next = vec_next | 16'h0001;
        vma_next  = 1'b1;
      end
      S_RUN: begin
        rnw_next = CORE_RNW_I | ~CORE_VALID_I;
        vma_next = CORE_VALID_I;
      end
      S_PUSH: begin
        addr_next = sp_next;
        wd_next   = push_byte(cnt_next, CORE_PC_I, INDEX_REG_I,
                              ACCUMULATORS_I, CONDITION_FLAGS_I,
                              mask_reg);
        rnw_next  = 1'b0;
        vma_next  = 1'b1;
      end
      S_PULL: begin
        addr_next = sp_next + 16'h0001;
        vma_next  = 1'b1;
      end
      S_WAIT: ba_next = 1'b1;
      S_HALT: ba_next = 1'b1;
      default: addr_next = `RESET_ADDR;
    endcase
    if (freeze) begin
      addr_next = addr_reg;
      wd_next   = wd_reg;
      rnw_next  = rnw_reg;
      vma_next  = vma_reg;
      ba_next   = ba_reg;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      state_reg         <= S_RESET;
      cnt_reg           <= 3'h0;
      sp_reg            <= `SP_RESET;
      vec_reg           <= `VEC_RESET;
      mask_reg          <= 1'b1;
      nmi_pend_reg      <= 1'b0;
      nmi_d_reg         <= 1'b1;
      wai_reg           <= 1'b0;
      PC_O              <= 16'h0000;
      LOAD_PC_O         <= 1'b0;
      RESTORE_O         <= 1'b0;
      INDEX_REG_O       <= 16'h0000;
      ACCUMULATORS_O    <= 16'h0000;
      CONDITION_FLAGS_O <= 8'h00;
      addr_reg          <= `RESET_ADDR;
      wd_reg            <= 8'h00;
      rnw_reg           <= 1'b1;
      vma_reg           <= 1'b0;
      ba_reg            <= 1'b0;
      PRDATA_O          <= 32'h00000000;
    end else if (CE_I) begin
      state_reg         <= state_next;
      cnt_reg           <= cnt_next;
      sp_reg            <= sp_next;
      vec_reg           <= vec_next;
      mask_reg          <= mask_next;
      nmi_pend_reg      <= nmi_pend_next;
      nmi_d_reg         <= NMI_N_I;
      wai_reg           <= wai_next;
      PC_O              <= pc_next;
      LOAD_PC_O         <= load_next;
      RESTORE_O         <= restore_next;
      INDEX_REG_O       <= ix_next;
      ACCUMULATORS_O    <= acc_next;
      CONDITION_FLAGS_O <= flags_next;
      addr_reg          <= addr_next;
      wd_reg            <= wd_next;
      rnw_reg           <= rnw_next;
      vma_reg           <= vma_next;
      ba_reg            <= ba_next;
      if (PSEL_I && !PENABLE_I) begin
        case (PADDR_I)
          `OFS_CONTROL:   PRDATA_O <= {31'h0, mask_reg};
          `OFS_STACK_PTR: PRDATA_O <= {16'h0, sp_reg};
          `OFS_STATUS:    PRDATA_O <= {20'h0, ba_reg, ~IRQ_N_I,
                                       nmi_pend_reg, mask_reg,
                                       state_reg};
          `OFS_PROG_CNT:  PRDATA_O <= {16'h0, PC_O};
          default:        PRDATA_O <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  assign PREADY_O        = CE_I;
  assign PSLVERR_O       = PSEL_I & PENABLE_I & ~known_addr(PADDR_I);
  assign RUN_O           = (state_reg == S_RUN) & ~freeze;
  assign ADDR_O          = addr_reg;
  assign ADDR_OE_O       = ~freeze & ~ba_reg;
  assign DATA_O          = wd_reg;
  assign DATA_OE_O       = DATA_DRIVE_ENABLE_I & ~rnw_reg &
                           vma_reg & ~ba_reg;
  assign RNW_O           = rnw_reg;
  assign RNW_OE_O        = ~freeze & ~ba_reg;
  assign ADDRESS_VALID_O = vma_reg & ~freeze & ~ba_reg;
  assign BUS_RELEASED_O  = ba_reg & ~freeze;

endmodule // bus_int_sequencer

// [tb/seq_props.sv]
`timescale 1ns/1ps
module seq_props (
  input wire        CLOCK_I,
  input wire        RST_N_I,
  input wire        BUS_FLOAT_REQUEST_I,
  input wire        DATA_DRIVE_ENABLE_I,
  input wire        HALT_N_I,
  input wire        INSTR_DONE_I,
  input wire [15:0] ADDR_O,
  input wire        ADDR_OE_O,
  input wire        DATA_OE_O,
  input wire        RNW_O,
  input wire        RNW_OE_O,
  input wire        ADDRESS_VALID_O,
  input wire        BUS_RELEASED_O,
  input wire        RUN_O,
  input wire        LOAD_PC_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  // ****************************************
  // Pin rules
  // ****************************************
  AST_FLOAT_OFF: assert property (
    BUS_FLOAT_REQUEST_I |-> !ADDR_OE_O && !RNW_OE_O)
    else $error("address or rnw driven under float");
  AST_FLOAT_LOW: assert property (
    BUS_FLOAT_REQUEST_I |-> !ADDRESS_VALID_O && !BUS_RELEASED_O)
    else $error("valid or released high under float");
  AST_DBE_OFF: assert property (
    !DATA_DRIVE_ENABLE_I |-> !DATA_OE_O)
    else $error("data driven with enable low");
  AST_READ_OFF: assert property (
    RNW_O |-> !DATA_OE_O)
    else $error("data driven in read cycle");
  AST_RELEASED: assert property (
    BUS_RELEASED_O |-> !(ADDR_OE_O || DATA_OE_O || RNW_OE_O
                         || ADDRESS_VALID_O || RUN_O))
    else $error("bus active while released");
  AST_IDLE_READ: assert property (
    RNW_OE_O && !ADDRESS_VALID_O |-> RNW_O)
    else $error("rnw low while idle");
  AST_IN_RESET: assert property (disable iff (1'b0)
    !RST_N_I && $past(!RST_N_I) |-> ADDR_O == 16'hfffe && RNW_O
      && !ADDRESS_VALID_O && !BUS_RELEASED_O && !DATA_OE_O)
    else $error("wrong pin state in reset");
  AST_RESTART: assert property (
    $rose(RST_N_I) && !BUS_FLOAT_REQUEST_I |=> ADDR_O == 16'hfffe
      && ADDRESS_VALID_O ##1 ADDR_O == 16'hffff ##1 LOAD_PC_O)
    else $error("restart vector fetch wrong");
  AST_VEC_IRQ: assert property (
    ADDRESS_VALID_O && ADDR_O == 16'hfff8 |=> ADDR_O == 16'hfff9 ##1 LOAD_PC_O)
    else $error("maskable vector fetch wrong");
  AST_VEC_NMI: assert property (
    ADDRESS_VALID_O && ADDR_O == 16'hfffc |=> ADDR_O == 16'hfffd ##1 LOAD_PC_O)
    else $error("non-maskable vector fetch wrong");
  AST_HALT: assert property (
    INSTR_DONE_I && RUN_O && !HALT_N_I && !BUS_FLOAT_REQUEST_I |=> BUS_RELEASED_O)
    else $error("no halt after instruction end");
  cover property ($rose(BUS_RELEASED_O));
  cover property (LOAD_PC_O);
  cover property (BUS_FLOAT_REQUEST_I && !ADDR_OE_O);
endmodule // seq_props

// [tb/mem_model.sv]
`timescale 1ns/1ps
module mem_model (
  input  wire        clk_i,
  input  wire [15:0] addr_i,
  input  wire        addr_oe_i,
  input  wire        valid_i,
  input  wire        rnw_i,
  input  wire [7:0]  wdata_i,
  input  wire        data_oe_i,
  output wire [7:0]  rdata_o
);
  reg  [7:0] mem [0:65535];
  reg  [7:0] last_reg;
  wire       rd_sel = valid_i && addr_oe_i && rnw_i;
  initial last_reg = 8'h00;
  // Unselected lines show the inverse of the last read
  assign rdata_o = rd_sel ? mem[addr_i] : ~last_reg;
  always @(posedge clk_i) begin
    if (rd_sel)
      last_reg <= mem[addr_i];
    if (valid_i && !rnw_i && data_oe_i)
      mem[addr_i] <= wdata_i;
  end
endmodule // mem_model

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "seq_consts.vh"
module testbench;
  reg         CLOCK_I, RST_N_I, PSEL_I, PENABLE_I, PWRITE_I;
  reg         BUS_FLOAT_REQUEST_I, DATA_DRIVE_ENABLE_I, HALT_N_I, CE_I;
  reg         IRQ_N_I, NMI_N_I, INSTR_DONE_I, CORE_RNW_I, CORE_VALID_I;
  reg         WAIT_FOR_INTERRUPT_OP_I, RETURN_FROM_INTERRUPT_OP_I;
  reg  [7:0]  PADDR_I, CORE_WDATA_I, CONDITION_FLAGS_I;
  reg  [15:0] CORE_ADDR_I, CORE_PC_I, INDEX_REG_I, ACCUMULATORS_I;
  reg  [31:0] PWDATA_I, rd;
  wire [31:0] PRDATA_O;
  wire [15:0] ADDR_O, PC_O, INDEX_REG_O, ACCUMULATORS_O;
  wire [7:0]  DATA_I, DATA_O, CONDITION_FLAGS_O;
  wire        PREADY_O, PSLVERR_O, ADDR_OE_O, DATA_OE_O, RNW_O, RNW_OE_O;
  wire        ADDRESS_VALID_O, BUS_RELEASED_O, RUN_O, LOAD_PC_O, RESTORE_O;
  integer     errors, checks_done, sp, i;
  reg         er;
  reg  [15:0] pc_v, ix_v, ac_v;
  reg  [7:0]  fl_v, v8;
  reg  [7:0]  q[$];

  bus_int_sequencer dut_u (.*);
  mem_model mem_u (.clk_i(CLOCK_I), .addr_i(ADDR_O), .addr_oe_i(ADDR_OE_O),
    .valid_i(ADDRESS_VALID_O), .rnw_i(RNW_O), .wdata_i(DATA_O),
    .data_oe_i(DATA_OE_O), .rdata_o(DATA_I));

  // ****************************************
  // Bench tasks
  // ****************************************
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge CLOCK_I);
      {PSEL_I, PWRITE_I, PADDR_I, PWDATA_I} <= {1'b1, w, a, d};
      @(posedge CLOCK_I);
      PENABLE_I <= 1'b1;
      do @(posedge CLOCK_I); while (PREADY_O !== 1'b1);
      rd = PRDATA_O;
      er = PSLVERR_O;
      {PSEL_I, PENABLE_I} <= 2'b00;
    end
  endtask
  task op(input [2:0] k);
    begin
      @(posedge CLOCK_I);
      {RETURN_FROM_INTERRUPT_OP_I, WAIT_FOR_INTERRUPT_OP_I, INSTR_DONE_I} <= k;
      @(posedge CLOCK_I);
      {RETURN_FROM_INTERRUPT_OP_I, WAIT_FOR_INTERRUPT_OP_I, INSTR_DONE_I} <= 0;
    end
  endtask
  task wait_load;
    integer n;
    begin
      n = 0;
      while (LOAD_PC_O !== 1'b1 && n < 40) begin
        @(negedge CLOCK_I);
        n = n + 1;
      end
      cmp(n < 40, 1);
    end
  endtask
  task new_core;
    begin
      @(posedge CLOCK_I);
      {pc_v, ix_v} = $urandom;
      {ac_v, fl_v, v8} = $urandom;
      {CORE_PC_I, INDEX_REG_I, ACCUMULATORS_I} <= {pc_v, ix_v, ac_v};
      CONDITION_FLAGS_I <= fl_v;
    end
  endtask
  task push_model(input m);
    begin
      q = {pc_v[7:0], pc_v[15:8], ix_v[7:0], ix_v[15:8], ac_v[7:0],
           ac_v[15:8], (fl_v & 8'h2f) | 8'hc0 | {3'b000, m, 4'h0}};
      for (i = 0; i < 7; i = i + 1)
        cmp(mem_u.mem[sp - i], q[i]);
      sp = sp - 7;
    end
  endtask
  function [15:0] vec(input [15:0] a);
    vec = {mem_u.mem[a], mem_u.mem[a + 16'h1]};
  endfunction
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    CLOCK_I = 1'b0;
    forever #50 CLOCK_I = ~CLOCK_I;
  end
  initial begin
    #300000;
    errors = errors + 1;
    tally_and_finish;
  end
  initial begin
    errors = 0;
    checks_done = 0;
    sp = 256;
    i = $urandom(32'h5c55b2ff);
    {PSEL_I, PENABLE_I, PWRITE_I, BUS_FLOAT_REQUEST_I, RST_N_I} = 0;
    {INSTR_DONE_I, WAIT_FOR_INTERRUPT_OP_I, RETURN_FROM_INTERRUPT_OP_I} = 0;
    {CORE_RNW_I, CORE_VALID_I, CORE_ADDR_I, CORE_WDATA_I, PADDR_I} = 0;
    {PWDATA_I, CORE_PC_I, INDEX_REG_I, ACCUMULATORS_I, CONDITION_FLAGS_I} = 0;
    {CE_I, DATA_DRIVE_ENABLE_I, HALT_N_I, IRQ_N_I, NMI_N_I} = 5'h1f;
    for (i = 16'hfff8; i < 65536; i = i + 1)
      mem_u.mem[i] = 8'($urandom);
    repeat (7) @(posedge CLOCK_I);
    @(negedge CLOCK_I);
    cmp({ADDR_O, ADDRESS_VALID_O, BUS_RELEASED_O, RNW_O, DATA_OE_O},
        {16'hfffe, 4'b0010});
    @(posedge CLOCK_I) RST_N_I <= 1'b1;
    wait_load;
    cmp(PC_O, vec(16'hfffe));
    apb(0, `OFS_STATUS, 0);
    cmp(rd[`STAT_MASK_BIT], 1);
    apb(1, `OFS_STACK_PTR, 32'h100);
    apb(0, 8'h20, 0);
    cmp({er, rd[30:0]}, 32'h8000_0000);
    apb(1, `OFS_CONTROL, 0);
    $display("test reset and registers done");
    new_core;
    IRQ_N_I <= 1'b0;
    op(3'b001);
    wait_load;
    cmp(PC_O, vec(16'hfff8));
    push_model(0);
    @(posedge CLOCK_I) IRQ_N_I <= 1'b1;
    op(3'b100);
    wait_load;
    cmp({PC_O, INDEX_REG_O}, {pc_v, ix_v});
    cmp({ACCUMULATORS_O, CONDITION_FLAGS_O, RESTORE_O}, {ac_v, q[6], 1'b1});
    sp = sp + 7;
    apb(0, `OFS_STATUS, 0);
    cmp(rd[`STAT_MASK_BIT], 0);
    $display("test irq and return done");
    apb(1, `OFS_CONTROL, 1);
    new_core;
    NMI_N_I <= 1'b0;
    op(3'b001);
    wait_load;
    cmp(PC_O, vec(16'hfffc));
    push_model(1);
    @(posedge CLOCK_I) NMI_N_I <= 1'b1;
    new_core;
    op(3'b010);
    repeat (12) @(negedge CLOCK_I);
    cmp(BUS_RELEASED_O, 1);
    @(posedge CLOCK_I) IRQ_N_I <= 1'b0;
    repeat (5) @(negedge CLOCK_I);
    cmp(BUS_RELEASED_O, 1);
    @(posedge CLOCK_I) NMI_N_I <= 1'b0;
    wait_load;
    cmp(PC_O, vec(16'hfffc));
    push_model(1);
    apb(0, `OFS_STACK_PTR, 0);
    cmp(rd, sp);
    {IRQ_N_I, NMI_N_I, HALT_N_I} <= 3'b110;
    op(3'b001);
    repeat (2) @(negedge CLOCK_I);
    cmp(BUS_RELEASED_O, 1);
    @(posedge CLOCK_I) NMI_N_I <= 1'b0;
    repeat (4) @(negedge CLOCK_I);
    cmp(BUS_RELEASED_O, 1);
    @(posedge CLOCK_I) HALT_N_I <= 1'b1;
    wait_load;
    cmp(PC_O, vec(16'hfffc));
    push_model(1);
    @(posedge CLOCK_I) NMI_N_I <= 1'b1;
    $display("test nmi, wait and halt done");
    @(posedge CLOCK_I) CE_I <= 1'b0;
    op(3'b010);
    @(posedge CLOCK_I) CE_I <= 1'b1;
    @(negedge CLOCK_I);
    cmp({RUN_O, BUS_RELEASED_O, PREADY_O}, 3'b101);
    @(posedge CLOCK_I);
    {CORE_ADDR_I, CORE_WDATA_I, CORE_RNW_I, CORE_VALID_I} <= {16'h0200, v8, 2'b01};
    @(posedge CLOCK_I) CORE_VALID_I <= 1'b0;
    repeat (3) @(negedge CLOCK_I);
    cmp(mem_u.mem[16'h0200], v8);
    @(posedge CLOCK_I);
    {BUS_FLOAT_REQUEST_I, DATA_DRIVE_ENABLE_I} <= 2'b10;
    repeat (3) @(negedge CLOCK_I);
    cmp({ADDR_OE_O, RNW_OE_O, ADDRESS_VALID_O, BUS_RELEASED_O}, 0);
    @(posedge CLOCK_I);
    {BUS_FLOAT_REQUEST_I, DATA_DRIVE_ENABLE_I} <= 2'b01;
    @(posedge CLOCK_I) RST_N_I <= 1'b0;
    repeat (3) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    wait_load;
    cmp(PC_O, vec(16'hfffe));
    $display("test bus and second reset done");
    tally_and_finish;
  end
endmodule // testbench

bind bus_int_sequencer seq_props chk_u (.*);
